// >>> core/twsp_pkg.sv
// Purpose: Shared constants and types for the wake/shutdown and PA config
// Assumes: sys_clk at 100 MHz stands in for the crystal-side logic clock
// Notes:   Register offsets and field positions live here only
package twsp_pkg;

  // Clock and time figures
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned BUFFERED_CLOCK_OUTPUT_DELAY_US  = 80;
  localparam int unsigned BUFFERED_CLOCK_OUTPUT_DELAY_CYC = BUFFERED_CLOCK_OUTPUT_DELAY_US * CLK_MHZ;
  localparam int unsigned IDLE_CNT_BITS    = 12;
  localparam int unsigned OSC_START_CYC    = 16;
  localparam int unsigned PLL_LOCK_CYC     = 16;
  localparam int unsigned BUF_CLK_DIV      = 4;

  // Crystal divider ratios, divide by 4, 5, 6
  localparam logic [2:0] XDIV_RATIO_00 = 3'h4;
  localparam logic [2:0] XDIV_RATIO_01 = 3'h5;
  localparam logic [2:0] XDIV_RATIO_10 = 3'h6;

  // Register offsets
  localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SHUTDOWN_AND_BOOST_CONTROL_BOOST   = 8'h05;
  localparam logic [7:0] OFS_AMP_POWER    = 8'h06;
  localparam logic [7:0] OFS_TUNE_CAP     = 8'h07;

  // Field positions
  localparam int unsigned XDIV_LSB    = 4;
  localparam int unsigned BOOST_BIT   = 0;
  localparam int unsigned AMP_PWR_LSB = 0;
  localparam int unsigned TUNE_LSB    = 0;

  // Reset values
  localparam logic [7:0] RST_CLOCK_CONFIG = 8'h10;
  localparam logic [7:0] RST_SHUTDOWN_AND_BOOST_CONTROL_BOOST   = 8'h00;
  localparam logic [7:0] RST_AMP_POWER    = 8'h07;
  localparam logic [7:0] RST_TUNE_CAP     = 8'h00;

  localparam logic [2:0] AMP_PWR_MAX = 3'h7;
  localparam logic [4:0] TUNE_ZERO   = 5'h00;

  typedef enum logic [2:0] {
    TWSP_SHUTDOWN, TWSP_OSC_START, TWSP_PLL_LOCK, TWSP_RUN
  } twsp_state_t;

  // Register write strobe with address and data
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } twsp_wr_t;

  // Analog-facing PA configuration
  typedef struct packed {
    logic [2:0] amp_power;
    logic       duty_boost;
    logic [4:0] tune_cap;
  } twsp_pa_cfg_t;

endpackage

// >>> core/twsp_timebase.sv
// Purpose: Divides the crystal-side clock to the 20 MHz time base tick at the divide-by-5 ratio
// Assumes: Ratio code 11 is illegal and falls back to divide by 5
// Notes:   Tick is a one-cycle enable, never a derived clock
`timescale 1ns/1ps
module twsp_timebase (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] div_sel,
  output logic            tick
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] ratio;

  // Ratio select from divider field
  assign ratio = (div_sel == 2'h0) ? twsp_pkg::XDIV_RATIO_00 :
                 (div_sel == 2'h2) ? twsp_pkg::XDIV_RATIO_10 :
                                     twsp_pkg::XDIV_RATIO_01;
  assign tick  = run && (cnt_q == ratio - 3'h1);
  assign cnt_d = (!run || tick) ? 3'h0 : cnt_q + 3'h1;

  // Divider counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// >>> core/twsp_core.sv
// Purpose: Wake, auto-shutdown, clock output and PA configuration
// Assumes: Registers written through a decoded serial-bus write strobe
// Notes:   Time base tick comes from twsp_timebase
`timescale 1ns/1ps
module twsp_core (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   data_in,
  input  wire logic                   mode_select_low_pin,
  input  wire logic                   mode_select_high_pin,
  input  wire twsp_pkg::twsp_wr_t     reg_wr,
  input  wire logic [7:0]             reg_rd_addr,
  output logic [7:0]                  reg_rd_data,
  output logic                        osc_enable,
  output logic                        synth_enable,
  output logic                        pa_ready,
  output logic                        buffered_clock_output,
  output twsp_pkg::twsp_pa_cfg_t      pa_cfg,
  output logic                        shutdown
);

  twsp_pkg::twsp_state_t state_q;
  twsp_pkg::twsp_state_t state_d;
  logic [7:0]  clock_config_q;
  logic [7:0]  shutdown_and_boost_control_boost_q;
  logic [7:0]  amp_power_q;
  logic [7:0]  tune_cap_q;
  logic [11:0] idle_q;
  logic [4:0]  step_q;
  logic [13:0] clk_dly_q;
  logic [1:0]  ckdiv_q;
  logic        ck_q;
  logic        tb_seen_q;
  logic        data_q;
  logic        tick;
  logic        preset_mode;
  logic        wake_req;
  logic        idle_done;
  logic        clk_ready;
  logic        wr_hit;
  logic [2:0]  amp_field;
  logic [4:0]  tune_field;
  logic        boost_field;
  twsp_pkg::twsp_pa_cfg_t pa_cfg_d;

  // Mode decode from strap pins
  assign preset_mode = mode_select_low_pin | mode_select_high_pin;
  assign wr_hit      = reg_wr.wr && !preset_mode;
  assign wake_req    = preset_mode ? (data_in && !data_q) : wr_hit;
  assign idle_done   = preset_mode && tick && !data_in
                       && (idle_q == 12'hFFF);
  assign clk_ready   = clk_dly_q == 14'(twsp_pkg::BUFFERED_CLOCK_OUTPUT_DELAY_CYC);

  twsp_timebase u_tb (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (osc_enable),
    .div_sel (clock_config_q[twsp_pkg::XDIV_LSB +: 2]),
    .tick    (tick)
  );

  // Field views of registers
  assign amp_field   = amp_power_q[twsp_pkg::AMP_PWR_LSB +: 3];
  assign tune_field  = tune_cap_q[twsp_pkg::TUNE_LSB +: 5];
  assign boost_field = shutdown_and_boost_control_boost_q[twsp_pkg::BOOST_BIT];
  assign pa_cfg_d.amp_power  = preset_mode ? twsp_pkg::AMP_PWR_MAX
                                           : amp_field;
  assign pa_cfg_d.tune_cap   = preset_mode ? twsp_pkg::TUNE_ZERO
                                           : tune_field;
  assign pa_cfg_d.duty_boost = preset_mode ? 1'b0 : boost_field;

  // Read mux
  assign reg_rd_data =
    (reg_rd_addr == twsp_pkg::OFS_CLOCK_CONFIG) ? clock_config_q :
    (reg_rd_addr == twsp_pkg::OFS_SHUTDOWN_AND_BOOST_CONTROL_BOOST)   ? shutdown_and_boost_control_boost_q :
    (reg_rd_addr == twsp_pkg::OFS_AMP_POWER)    ? amp_power_q :
    (reg_rd_addr == twsp_pkg::OFS_TUNE_CAP)     ? tune_cap_q : 8'h00;

  // Power state outputs
  assign osc_enable   = state_q != twsp_pkg::TWSP_SHUTDOWN;
  assign synth_enable = state_q == twsp_pkg::TWSP_PLL_LOCK
                        || state_q == twsp_pkg::TWSP_RUN;
  assign pa_ready     = state_q == twsp_pkg::TWSP_RUN;
  assign shutdown     = state_q == twsp_pkg::TWSP_SHUTDOWN;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      twsp_pkg::TWSP_SHUTDOWN: begin
        if (wake_req) begin
          state_d = twsp_pkg::TWSP_OSC_START;
        end
      end
      twsp_pkg::TWSP_OSC_START: begin
        if (step_q == 5'(twsp_pkg::OSC_START_CYC - 1)) begin
          state_d = twsp_pkg::TWSP_PLL_LOCK;
        end
      end
      twsp_pkg::TWSP_PLL_LOCK: begin
        if (step_q == 5'(twsp_pkg::PLL_LOCK_CYC - 1)) begin
          state_d = twsp_pkg::TWSP_RUN;
        end
      end
      twsp_pkg::TWSP_RUN: begin
        if (idle_done) begin
          state_d = twsp_pkg::TWSP_SHUTDOWN;
        end
      end
      default: state_d = twsp_pkg::TWSP_SHUTDOWN;
    endcase
  end

  // State and step counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= twsp_pkg::TWSP_SHUTDOWN;
      step_q  <= 5'h00;
      data_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q  <= (state_d != state_q) ? 5'h00 : step_q + 5'h01;
      data_q  <= data_in;
    end
  end

  // Idle counter, counts time base ticks while data is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q    <= 12'h000;
      tb_seen_q <= 1'b0;
    end else if (!preset_mode || shutdown) begin
      idle_q    <= 12'h000;
      tb_seen_q <= 1'b0;
    end else if (data_in) begin
      idle_q    <= 12'h000;
      tb_seen_q <= tb_seen_q | tick;
    end else if (tick) begin
      idle_q    <= tb_seen_q ? idle_q + 12'h001 : 12'h000;
      tb_seen_q <= 1'b1;
    end
  end

  // Clock output delay and divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_dly_q <= 14'h0000;
      ckdiv_q   <= 2'h0;
      ck_q      <= 1'b0;
    end else if (!osc_enable) begin
      clk_dly_q <= 14'h0000;
      ckdiv_q   <= 2'h0;
      ck_q      <= 1'b0;
    end else begin
      if (!clk_ready && (tick || clk_dly_q != 14'h0000)) begin
        clk_dly_q <= clk_dly_q + 14'h0001;
      end
      if (clk_ready && tick) begin
        ckdiv_q <= ckdiv_q + 2'h1;
        if (ckdiv_q == 2'(twsp_pkg::BUF_CLK_DIV / 2 - 1)) begin
          ck_q    <= ~ck_q;
          ckdiv_q <= 2'h0;
        end
      end
    end
  end
  assign buffered_clock_output = ck_q;

  // Registers and PA configuration flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_config_q <= twsp_pkg::RST_CLOCK_CONFIG;
      shutdown_and_boost_control_boost_q   <= twsp_pkg::RST_SHUTDOWN_AND_BOOST_CONTROL_BOOST;
      amp_power_q    <= twsp_pkg::RST_AMP_POWER;
      tune_cap_q     <= twsp_pkg::RST_TUNE_CAP;
      pa_cfg         <= '0;
    end else begin
      pa_cfg <= pa_cfg_d;
      if (wr_hit && reg_wr.addr == twsp_pkg::OFS_CLOCK_CONFIG) begin
        clock_config_q <= reg_wr.data;
      end
      if (wr_hit && reg_wr.addr == twsp_pkg::OFS_SHUTDOWN_AND_BOOST_CONTROL_BOOST) begin
        shutdown_and_boost_control_boost_q <= reg_wr.data;
      end
      if (wr_hit && reg_wr.addr == twsp_pkg::OFS_AMP_POWER) begin
        amp_power_q <= reg_wr.data;
      end
      if (wr_hit && reg_wr.addr == twsp_pkg::OFS_TUNE_CAP) begin
        tune_cap_q <= reg_wr.data;
      end
    end
  end

  // Preset mode PA forcing
  preset_pa_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(preset_mode) |-> pa_cfg.amp_power == 3'h7
      && pa_cfg.tune_cap == 5'h00)
    else $error("Preset PA settings not forced");

  boost_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(preset_mode) |-> pa_cfg.duty_boost == $past(boost_field))
    else $error("Boost duty not following register");

  idle_shut_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    idle_done && pa_ready |=> shutdown)
    else $error("No shutdown at idle end");

  data_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    preset_mode && data_in && pa_ready |=> idle_q == 12'h000)
    else $error("Idle count not cleared by high data");

  wake_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    shutdown && wake_req |=> osc_enable && !synth_enable)
    else $error("Wake did not start oscillator");

  reg_no_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !preset_mode |-> !idle_done && idle_q == 12'h000)
    else $error("Idle logic active in register mode");

  mode_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_select_low_pin || mode_select_high_pin) |=>
      $stable(clock_config_q) && $stable(shutdown_and_boost_control_boost_q)
      && $stable(amp_power_q) && $stable(tune_cap_q))
    else $error("Register written while a select pin is set");

  clk_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clk_ready |-> !buffered_clock_output)
    else $error("Clock output before delay elapsed");

endmodule

// >>> verification/twsp_mcu_model.sv
// Purpose: Controller model that drives the single data line
// Assumes: Changes the line just after the falling clock edge, idles low
// Notes:   Tasks are called from the bench at a falling edge
`timescale 1ns/1ps
module twsp_mcu_model (
  input  wire logic sys_clk,
  output logic      data_in
);
  // Line idles low so the idle counter can run
  initial data_in = 1'b0;

  // Wake pulse longer than oscillator start plus lock, then settle gap
  task automatic wake(input int n);
    data_in = 1'b1;
    repeat (n) @(negedge sys_clk);
    data_in = 1'b0;
    repeat (1000) @(negedge sys_clk);
  endtask

  // Sends one byte MSB first, ten clocks a bit, then low again
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      data_in = b[i];
      repeat (10) @(negedge sys_clk);
    end
    data_in = 1'b0;
  endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for wake, idle shutdown and PA config
// Assumes: Divider reset value gives a tick every five clocks
// Notes:   Inputs change at the falling edge only
`timescale 1ns/1ps
module tb_top;
  logic                   sys_clk = 1'b0;
  logic                   rst_n   = 1'b0;
  logic                   sel_lo  = 1'b0;
  logic                   sel_hi  = 1'b0;
  logic [7:0]             rd_addr = 8'h00;
  logic [7:0]             rd_data;
  logic                   osc, synth, ready, clko, clko_q, shutdown_and_boost_control, data_in;
  twsp_pkg::twsp_wr_t     reg_wr  = '0;
  twsp_pkg::twsp_pa_cfg_t pa_cfg;
  int                     n_fail  = 0;
  int                     checks  = 0;
  int                     cyc     = 0;
  int                     tog     = 0;
  int                     k;

  // Free-running clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  twsp_mcu_model mcu_u (.sys_clk(sys_clk), .data_in(data_in));

  twsp_core dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .data_in(data_in),
    .mode_select_low_pin(sel_lo), .mode_select_high_pin(sel_hi),
    .reg_wr(reg_wr), .reg_rd_addr(rd_addr), .reg_rd_data(rd_data),
    .osc_enable(osc), .synth_enable(synth), .pa_ready(ready),
    .buffered_clock_output(clko), .pa_cfg(pa_cfg), .shutdown(shutdown_and_boost_control));

  // Counts clock output toggles and cuts a hang short
  always @(posedge sys_clk) begin
    clko_q <= clko;
    if (clko_q !== clko) tog++;
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic w(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One write strobe per clock; caller drops the strobe afterwards
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr = '{1'b1, a, d};
    @(negedge sys_clk);
  endtask

  // Combinational read, then back to a falling edge so drives avoid posedge
  task automatic rd(logic [7:0] a, logic [7:0] exp, string nm);
    rd_addr = a;
    #1;
    check(nm, rd_data, exp);
    @(negedge sys_clk);
  endtask

  // Toggle count over a window must fall in lo..hi
  task automatic tog_count(int n, int lo, int hi);
    tog = 0;
    w(n);
    check("clk_toggles", 9'((tog >= lo) && (tog <= hi)), 9'h001);
  endtask

  // Main sequence
  initial begin
    w(10);
    rst_n = 1'b1;
    w(1);
    rd(8'h00, 8'h10, "clock_config");
    rd(8'h05, 8'h00, "shutdown_and_boost_control_boost");
    rd(8'h06, 8'h07, "amp_power");
    rd(8'h07, 8'h00, "tune_cap");
    rd(8'h01, 8'h00, "unmapped");
    check("shutdown_rst", shutdown_and_boost_control, 9'h001);
    $display("test reset_values done");
    wr(8'h07, 8'h1F);
    wr(8'h06, 8'h03);
    wr(8'h05, 8'h01);
    reg_wr.wr = 1'b0;
    check("osc_reg_wake", osc, 9'h001);
    w(2);
    check("pa_cfg_reg", pa_cfg, {3'h3, 1'b1, 5'h1F});
    $display("test register_writes done");
    w(8400);
    tog_count(400, 39, 41);
    wr(8'h00, 8'h00);
    reg_wr.wr = 1'b0;
    w(50);
    tog_count(400, 49, 51);
    wr(8'h00, 8'h10);
    reg_wr.wr = 1'b0;
    $display("test divider done");
    w(21000);
    check("no_idle_shutdown_and_boost_control", shutdown_and_boost_control, 9'h000);
    $display("test register_mode_idle done");
    sel_hi = 1'b1;
    wr(8'h07, 8'h05);
    reg_wr.wr = 1'b0;
    w(3);
    check("pa_cfg_preset", pa_cfg, {3'h7, 1'b0, 5'h00});
    rd(8'h07, 8'h1F, "tune_refused");
    $display("test preset_forcing done");
    w(15000);
    mcu_u.send(8'h01);
    w(15000);
    check("kept_awake", shutdown_and_boost_control, 9'h000);
    w(5450);
    check("idle_early", shutdown_and_boost_control, 9'h000);
    w(80);
    check("idle_shutdown_and_boost_control", shutdown_and_boost_control, 9'h001);
    $display("test idle_shutdown done");
    tog = 0;
    fork
      mcu_u.wake(40);
      begin
        k = 0;
        while (osc !== 1'b1 && k < 3) begin
          w(1);
          k++;
        end
        check("osc_rise", 9'(k <= 2), 9'h001);
        w(15);
        check("synth_early", synth, 9'h000);
        w(1);
        check("synth_on", synth, 9'h001);
        w(15);
        check("ready_early", ready, 9'h000);
        w(1);
        check("ready_on", ready, 9'h001);
      end
    join
    mcu_u.send(8'hA5);
    check("awake_data", shutdown_and_boost_control, 9'h000);
    w(6720);
    check("clk_quiet", 9'(tog == 0), 9'h001);
    w(600);
    check("clk_started", 9'(tog >= 20), 9'h001);
    $display("test wake done");
    report_and_stop();
  end
endmodule
